/* File: hw/ast_baud_gen.sv */
// baud generator: 8-bit divisor then x16 or x64 prescale to bit ticks
// assumes run, restart and divisor are synchronous to aclk
`timescale 1ns/1ps
`include "ast_map.svh"

module ast_baud_gen
  import ast_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [7:0] divisor,
  input  wire logic       high_speed,
  input  wire logic       run,
  input  wire logic       restart,
  output logic            bit_tick
);

  logic [7:0] div_cnt_q;
  logic [5:0] pre_cnt_q;
  logic       sub_tick;
  logic [5:0] pre_max;

  assign sub_tick = (div_cnt_q == 8'h00);
  assign pre_max  = high_speed ? `AST_PRESCALE_FAST : `AST_PRESCALE_SLOW;
  // tick on the edge ending the last sub tick, so every bit is a full period
  assign bit_tick = run && !restart && sub_tick && (pre_cnt_q >= pre_max);

  // divisor counter; restart preloads the divisor so the start bit is not short
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      div_cnt_q <= 8'h00;
    else if (restart)
      div_cnt_q <= divisor;
    else if (run)
      div_cnt_q <= sub_tick ? divisor : div_cnt_q - 8'h01;
  end

  // prescaler, one bit tick per 16 or 64 sub ticks
  always_ff @(posedge aclk)
  begin
    if (!aresetn || restart)
      pre_cnt_q <= 6'h00;
    else if (run && sub_tick)
      pre_cnt_q <= (pre_cnt_q >= pre_max) ? 6'h00 : pre_cnt_q + 6'h01;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_TICK_SPACING : assert property (
    bit_tick |=> (!bit_tick && !restart) [*8] or ##[1:8] restart)
    else $error("bit ticks closer than the prescale allows");

endmodule

/* File: hw/ast_map.svh */
// address map, field positions, reset values and timing counts
// assumes inclusion by the async serial transmitter design files only
`ifndef AST_MAP_SVH
`define AST_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define AST_OFS_IRQ_FLAGS    8'h00
`define AST_OFS_IRQ_ENABLES  8'h04
`define AST_OFS_IRQ_PRIOS    8'h08
`define AST_OFS_RX_STAT_CTRL 8'h0c
`define AST_OFS_TX_BUFFER    8'h10
`define AST_OFS_TX_STAT_CTRL 8'h14
`define AST_OFS_BAUD_DIV     8'h18
`define AST_OFS_POWER_CTRL   8'h1c

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define AST_BIT_TX_FLAG      4
`define AST_BIT_TX_IRQ_EN    4
`define AST_BIT_SERIAL_EN    7
`define AST_BIT_CLK_SRC      7
`define AST_BIT_NINE_SEL     6
`define AST_BIT_TX_EN        5
`define AST_BIT_SYNC_SEL     4
`define AST_BIT_HIGH_SPEED   2
`define AST_BIT_SHIFT_EMPTY  1
`define AST_BIT_NINTH        0
`define AST_BIT_SLEEP        0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define AST_RST_IRQ_ENABLES  8'h00
`define AST_RST_IRQ_PRIOS    8'hff
`define AST_RST_RX_STAT_CTRL 8'h00
`define AST_RST_TX_BUFFER    8'h00
`define AST_RST_BAUD_DIV     8'h00

// ----------------------------------------------------------------
// timing and frame counts
// ----------------------------------------------------------------
`define AST_CLK_PERIOD_PS    25000
`define AST_TCY_NS           100
`define AST_TCY_CYCLES       ((`AST_TCY_NS * 1000) / `AST_CLK_PERIOD_PS)
`define AST_PRESCALE_FAST    6'd15
`define AST_PRESCALE_SLOW    6'd63
`define AST_FRAME_BITS_8     4'd10
`define AST_FRAME_BITS_9     4'd11

`endif

/* File: hw/ast_pkg.sv */
// types shared by the async serial transmitter
// assumes nothing beyond a SystemVerilog compiler
package ast_pkg;

  // axi4-lite response codes
  typedef enum logic [1:0]
  {
    AST_RESP_OKAY   = 2'b00,
    AST_RESP_SLVERR = 2'b10
  } ast_resp_t;

  // data byte plus optional ninth bit
  typedef logic [8:0] ast_char_t;

endpackage

/* File: hw/ast_shifter.sv */
// transmit shift register: start bit, 8 or 9 data bits lsb first, stop bit
// assumes load only while empty and bit_tick from the baud generator
`timescale 1ns/1ps
`include "ast_map.svh"

module ast_shifter
  import ast_pkg::*;
(
  input  wire logic      aclk,
  input  wire logic      aresetn,
  input  wire logic      load,
  input  wire ast_char_t data,
  input  wire logic      nine,
  input  wire logic      bit_tick,
  input  wire logic      abort,
  output logic           line,
  output logic           empty
);

  logic [10:0] sr_q;
  logic [3:0]  bits_left_q;

  assign line  = sr_q[0];
  assign empty = (bits_left_q == 4'h0);

  // frame shifting, ones fill behind the stop bit
  always_ff @(posedge aclk)
  begin
    if (!aresetn || abort)
    begin
      sr_q        <= 11'h7ff;
      bits_left_q <= 4'h0;
    end
    else if (load)
    begin
      sr_q        <= {1'b1, (nine ? data[8] : 1'b1), data[7:0], 1'b0};
      bits_left_q <= nine ? `AST_FRAME_BITS_9 : `AST_FRAME_BITS_8;
    end
    else if (bit_tick && !empty)
    begin
      sr_q        <= {1'b1, sr_q[10:1]};
      bits_left_q <= bits_left_q - 4'h1;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_LSB_FIRST : assert property (
    load && !abort |=> !line && sr_q[1] == $past(data[0]))
    else $error("frame does not open with start bit then lsb");

endmodule

/* File: hw/ast_uart_tx.sv */
// async serial transmitter top: axi4-lite registers, buffer, flag logic
// assumes an axi4-lite master on aclk and a receiver on tx_line
//
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "ast_map.svh"

// Functional notes
// - start, eight or nine data, one stop
// - data bits leave lsb first
// - eight-bit programmable baud divisor
// - bit clock x16 fast, x64 slow
// - no hardware parity, ninth bit carries it
// - sleep halts asynchronous operation
// - async only while sync select clear
// - reload shifter only after stop bit
// - move takes one cycle, sets flag
// - flag sets regardless of irq enable
// - flag clears only by buffer write
// - flag clear shows in second cycle
// - polled shift-empty status, no irq
// - shift register has no address
// - setting transmit enable sets flag
// - ninth bit loaded before data byte
// - buffer write starts sending when free
// - shared format and rate with receiver
// - baud divisor resets to zero
// - rate table figures assume x16 timing
module ast_uart_tx
  import ast_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             tx_line,
  output logic             tx_irq_request
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic        aw_held_q;
  logic        w_held_q;
  logic [7:0]  aw_addr_q;
  logic [7:0]  w_byte_q;
  logic        w_lane0_q;
  logic        do_write;
  logic        wr_lane;
  logic        addr_ok;
  logic [31:0] rd_word;
  logic        rd_ok;

  logic [7:0]  irq_enables_q;
  logic [7:0]  irq_prios_q;
  logic [7:0]  rx_stat_ctrl_q;
  logic [7:0]  transmit_buffer_q;
  logic        clock_source_select_q;
  logic        nine_bit_select_q;
  logic        transmit_enable_q;
  logic        sync_select_q;
  logic        high_speed_select_q;
  logic        ninth_tx_bit_q;
  logic [7:0]  baud_divisor_q;
  logic        sleep_q;

  logic        buffer_empty_flag_q;
  logic        buf_full_q;
  logic [3:0]  move_cnt_q;
  logic [3:0]  lag_cnt_q;
  logic        clear_due;
  logic        tx_active;
  logic        move_ready;
  logic        load;
  logic        transmit_enable_set;
  logic        wr_txbuf;
  logic        wr_transmit_status_control;
  logic        bit_tick;
  logic        shift_line;
  logic        shift_empty_status;

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wr_lane  = do_write && w_lane0_q;

  // address and data are taken in either order and held
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_byte_q      <= 8'h00;
      w_lane0_q     <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_held_q && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      else if (do_write)
        aw_held_q <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_q  <= 1'b1;
        w_byte_q  <= s_axi_wdata[7:0];
        w_lane0_q <= s_axi_wstrb[0];
      end
      else if (do_write)
        w_held_q <= 1'b0;
    end
  end

  // decode of mapped word addresses
  always_comb
  begin
    unique case (aw_addr_q)
      `AST_OFS_IRQ_FLAGS, `AST_OFS_IRQ_ENABLES, `AST_OFS_IRQ_PRIOS,
      `AST_OFS_RX_STAT_CTRL, `AST_OFS_TX_BUFFER, `AST_OFS_TX_STAT_CTRL,
      `AST_OFS_BAUD_DIV, `AST_OFS_POWER_CTRL: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // write response, slverr on unmapped address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= AST_RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= addr_ok ? AST_RESP_OKAY : AST_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  assign wr_txbuf = wr_lane && (aw_addr_q == `AST_OFS_TX_BUFFER);
  assign wr_transmit_status_control = wr_lane && (aw_addr_q == `AST_OFS_TX_STAT_CTRL);
  assign transmit_enable_set = wr_transmit_status_control && w_byte_q[`AST_BIT_TX_EN] && !transmit_enable_q;

  // irq enable, priority, receive control, power control
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_enables_q  <= `AST_RST_IRQ_ENABLES;
      irq_prios_q    <= `AST_RST_IRQ_PRIOS;
      rx_stat_ctrl_q <= `AST_RST_RX_STAT_CTRL;
      sleep_q        <= 1'b0;
    end
    else if (wr_lane)
    begin
      if (aw_addr_q == `AST_OFS_IRQ_ENABLES)
        irq_enables_q <= w_byte_q;
      if (aw_addr_q == `AST_OFS_IRQ_PRIOS)
        irq_prios_q <= w_byte_q;
      if (aw_addr_q == `AST_OFS_RX_STAT_CTRL)
        rx_stat_ctrl_q <= {w_byte_q[7:3], 3'b000}; // receiver status not built
      if (aw_addr_q == `AST_OFS_POWER_CTRL)
        sleep_q <= w_byte_q[`AST_BIT_SLEEP];
    end
  end

  // transmit control and baud divisor; divisor zero on reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      clock_source_select_q <= 1'b0;
      nine_bit_select_q     <= 1'b0;
      transmit_enable_q     <= 1'b0;
      sync_select_q         <= 1'b0;
      high_speed_select_q   <= 1'b0;
      ninth_tx_bit_q        <= 1'b0;
      baud_divisor_q        <= `AST_RST_BAUD_DIV;
    end
    else
    begin
      if (wr_transmit_status_control)
      begin
        clock_source_select_q <= w_byte_q[`AST_BIT_CLK_SRC];
        nine_bit_select_q     <= w_byte_q[`AST_BIT_NINE_SEL];
        transmit_enable_q     <= w_byte_q[`AST_BIT_TX_EN];
        sync_select_q         <= w_byte_q[`AST_BIT_SYNC_SEL];
        high_speed_select_q   <= w_byte_q[`AST_BIT_HIGH_SPEED];
        ninth_tx_bit_q        <= w_byte_q[`AST_BIT_NINTH];
      end
      if (wr_lane && aw_addr_q == `AST_OFS_BAUD_DIV)
        baud_divisor_q <= w_byte_q;
    end
  end

  // ----------------------------------------------------------------
  // transmit buffer and buffer-empty flag
  // ----------------------------------------------------------------
  assign tx_active  = rx_stat_ctrl_q[`AST_BIT_SERIAL_EN] && transmit_enable_q
                      && !sync_select_q;
  assign move_ready = buf_full_q && shift_empty_status && tx_active && !sleep_q;
  assign load       = move_ready && (move_cnt_q == 4'(`AST_TCY_CYCLES - 1));
  assign clear_due  = (lag_cnt_q == 4'h1);

  // buffer holds the byte until the shifter is free
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      transmit_buffer_q <= `AST_RST_TX_BUFFER;
      buf_full_q        <= 1'b0;
    end
    else if (wr_txbuf)
    begin
      transmit_buffer_q <= w_byte_q;
      buf_full_q        <= 1'b1;
    end
    else if (load)
      buf_full_q <= 1'b0;
  end

  // move into the shifter spans one instruction cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !move_ready || load)
      move_cnt_q <= 4'h0;
    else
      move_cnt_q <= move_cnt_q + 4'h1;
  end

  // clear of the flag lags a buffer write by one instruction cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      lag_cnt_q <= 4'h0;
    else if (wr_txbuf)
      lag_cnt_q <= 4'(`AST_TCY_CYCLES);
    else if (lag_cnt_q != 4'h0)
      lag_cnt_q <= lag_cnt_q - 4'h1;
  end

  // flag: set wins over the delayed clear, no software clear path
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      buffer_empty_flag_q <= 1'b0;
    else if (load || transmit_enable_set)
      buffer_empty_flag_q <= 1'b1;
    else if (clear_due)
      buffer_empty_flag_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // baud generator and shifter
  // ----------------------------------------------------------------
  ast_baud_gen u_baud
  (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .divisor    (baud_divisor_q),
    .high_speed (high_speed_select_q),
    .run        (tx_active && !sleep_q),
    .restart    (load || !tx_active),
    .bit_tick   (bit_tick)
  );

  // shifter sits behind the buffer only, no bus path to it
  ast_shifter u_shift
  (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .load     (load),
    .data     ({ninth_tx_bit_q, transmit_buffer_q}),
    .nine     (nine_bit_select_q),
    .bit_tick (bit_tick),
    .abort    (!tx_active),
    .line     (shift_line),
    .empty    (shift_empty_status)
  );

  // line and irq request registered; idle holds mark
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_line        <= 1'b1;
      tx_irq_request <= 1'b0;
    end
    else
    begin
      tx_line        <= tx_active ? shift_line : 1'b1;
      tx_irq_request <= buffer_empty_flag_q && irq_enables_q[`AST_BIT_TX_IRQ_EN];
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  // read mux, shift-empty is live status
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    unique case (s_axi_araddr)
      `AST_OFS_IRQ_FLAGS:    rd_word[`AST_BIT_TX_FLAG] = buffer_empty_flag_q;
      `AST_OFS_IRQ_ENABLES:  rd_word[7:0] = irq_enables_q;
      `AST_OFS_IRQ_PRIOS:    rd_word[7:0] = irq_prios_q;
      `AST_OFS_RX_STAT_CTRL: rd_word[7:0] = rx_stat_ctrl_q;
      `AST_OFS_TX_BUFFER:    rd_word[7:0] = transmit_buffer_q;
      `AST_OFS_TX_STAT_CTRL: rd_word[7:0] = {clock_source_select_q, nine_bit_select_q,
                                             transmit_enable_q, sync_select_q, 1'b0,
                                             high_speed_select_q, shift_empty_status,
                                             ninth_tx_bit_q};
      `AST_OFS_BAUD_DIV:     rd_word[7:0] = baud_divisor_q;
      `AST_OFS_POWER_CTRL:   rd_word[`AST_BIT_SLEEP] = sleep_q;
      default:               rd_ok = 1'b0;
    endcase
  end

  // one read at a time, answer one cycle after acceptance
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= AST_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_ok ? AST_RESP_OKAY : AST_RESP_SLVERR;
    end
    else if (s_axi_rvalid)
    begin
      if (s_axi_rready)
      begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
    else
      s_axi_arready <= 1'b1;
  end

  // ----------------------------------------------------------------
  // assertions and covers
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_IDLE_MARK : assert property (
    !tx_active |=> tx_line)
    else $error("line not at mark while transmitter inactive");

  AST_START_BIT : assert property (
    load ##1 tx_active |=> !tx_line)
    else $error("no start bit after shifter load");

  AST_NO_EARLY_RELOAD : assert property (
    load |-> shift_empty_status && $past(shift_empty_status, 3))
    else $error("shifter reloaded before stop bit finished");

  AST_MOVE_SETS_FLAG : assert property (
    load |=> buffer_empty_flag_q && !buf_full_q || $past(wr_txbuf))
    else $error("move did not set flag or empty the buffer");

  AST_FLAG_HW_CLEAR_ONLY : assert property (
    $fell(buffer_empty_flag_q) |-> $past(wr_txbuf, 5))
    else $error("flag cleared without a buffer write");

  AST_FLAG_LAG : assert property (
    wr_txbuf && buffer_empty_flag_q |=> buffer_empty_flag_q [*3])
    else $error("flag cleared within the write's own cycle");

  AST_TRANSMIT_ENABLE_SETS_FLAG : assert property (
    transmit_enable_set |=> buffer_empty_flag_q [*4])
    else $error("enabling transmission left flag clear");

  AST_SLEEP_HOLDS_LINE : assert property (
    sleep_q && $past(sleep_q) && tx_active && $past(tx_active) |=> $stable(tx_line))
    else $error("line moved during sleep");

  AST_IRQ_GATE : assert property (
    ##1 tx_irq_request == $past(buffer_empty_flag_q && irq_enables_q[`AST_BIT_TX_IRQ_EN]))
    else $error("irq request not gated by enable");

  AST_SYNC_INHIBITS : assert property (
    sync_select_q |-> !load ##1 tx_line)
    else $error("asynchronous send while sync selected");

  AST_DIVISOR_RESET : assert property (
    $rose(aresetn) |-> baud_divisor_q == `AST_RST_BAUD_DIV)
    else $error("baud divisor not zero after reset");

  AST_COV_FRAME_DONE : cover property (
    !shift_empty_status ##1 shift_empty_status);

  AST_COV_BACK_TO_BACK : cover property (
    load ##[1:1000] (!shift_empty_status && buf_full_q));

  AST_COV_NINE_BIT : cover property (
    load && nine_bit_select_q && ninth_tx_bit_q);

endmodule

/* File: test/ast_rx_model.sv */
// receiver model: samples the serial line mid-bit, counts whole frames
// assumes bit_clks and nine are set by the bench before a frame starts
`timescale 1ns/1ps
module ast_rx_model
  import ast_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        line,
  input  wire logic [15:0] bit_clks,
  input  wire logic        nine,
  output ast_char_t        rx_char,
  output logic             rx_stop,
  output logic [7:0]       rx_count
);
  ast_char_t sh;
  // start edge, mid-bit data samples lsb first, then stop bit
  initial
  begin
    rx_char = '0;
    rx_stop = 1'b0;
    rx_count = 8'h00;
    forever
    begin
      @(negedge line);
      repeat (bit_clks / 2) @(posedge aclk);
      sh = '0;
      for (int i = 0; i < (nine ? 9 : 8); i++)
      begin
        repeat (bit_clks) @(posedge aclk);
        sh[i] = line;
      end
      repeat (bit_clks) @(posedge aclk);
      rx_stop = line;
      rx_char = sh;
      rx_count = rx_count + 8'h01;
    end
  end
endmodule

/* File: test/tb.sv */
// bench: axi4-lite register tasks, frames judged by the receiver model
// assumes ast_uart_tx with byte offsets from the map header
`timescale 1ns/1ps
module tb
  import ast_pkg::*;
  ;
  logic        aclk;
  logic        aresetn;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, got;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, tx_line, irq;
  logic [1:0]  bresp, rresp, resp;
  logic [15:0] bit_clks;
  logic        nine, rx_stop;
  ast_char_t   rx_char;
  logic [7:0]  rx_count;
  int          fails, checks_done, len;
  logic [7:0]  ofs[7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
  logic [7:0]  rv[7] = '{8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h02, 8'h00};

  ast_uart_tx ast_uart_tx_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tx_line(tx_line),
    .tx_irq_request(irq));

  ast_rx_model ast_rx_model_inst (.aclk(aclk), .line(tx_line), .bit_clks(bit_clks),
    .nine(nine), .rx_char(rx_char), .rx_stop(rx_stop), .rx_count(rx_count));

  // 40 mhz clock
  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // ----
  // report, compare and bus tasks
  // ----
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic bail(input string nm, input int n);
    if (n >= 20000)
    begin
      fails++;
      $display("[ERR] %s timed out", nm);
      wrap_up();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (!bvalid && n < 20000);
    resp = bresp;
    bready <= 1'b0;
    bail("write", n);
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (!rvalid && n < 20000);
    got = rdata;
    resp = rresp;
    rready <= 1'b0;
    bail("read", n);
  endtask

  // waits for the model's frame count to reach c
  task automatic wait_rx(input logic [7:0] c);
    int n;
    n = 0;
    while (rx_count !== c && n < 20000)
    begin
      @(posedge aclk);
      n++;
    end
    bail("frame", n);
  endtask

  // clocks the start bit of the next frame
  task automatic start_len();
    int n;
    n = 0;
    len = 0;
    while (tx_line !== 1'b0 && n < 20000)
    begin
      @(posedge aclk);
      n++;
    end
    while (tx_line === 1'b0 && len < 20000)
    begin
      @(posedge aclk);
      len++;
    end
    bail("start", n);
  endtask

  // ----
  // scenarios
  // ----
  initial
  begin
    {awaddr, wdata, awvalid, wvalid, bready, araddr, arvalid, rready} = '0;
    aresetn = 1'b0;
    bit_clks = 16'd16;
    nine = 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("idle", tx_line, 1);
    for (int i = 0; i < 7; i++)
    begin
      rd(ofs[i]);
      chk("reset", got, rv[i]);
      chk("rresp", resp, 2'b00);
    end
    rd(8'h20);
    chk("unmapped", resp, 2'b10);
    wr(8'h00, 8'h10);
    chk("wr_resp", resp, 2'b00);
    rd(8'h00);
    chk("flag_wr", got[4], 0);
    wr(8'h18, 8'h00);
    wr(8'h0c, 8'h80);
    wr(8'h14, 8'h24);
    rd(8'h00);
    chk("flag_en", got[4], 1);
    chk("irq_off", irq, 0);
    wr(8'h04, 8'h10);
    repeat (3) @(posedge aclk);
    chk("irq_on", irq, 1);
    wr(8'h10, 8'ha5);
    start_len();
    chk("bit16", len, 16);
    rd(8'h14);
    chk("busy", got[1], 0);
    rd(8'h00);
    chk("flag_mv", got[4], 1);
    wait_rx(8'd1);
    chk("data", rx_char, 9'h0a5);
    chk("stop", rx_stop, 1);
    repeat (16) @(posedge aclk);
    rd(8'h14);
    chk("empty", got[1], 1);
    wr(8'h10, 8'h96);
    repeat (8) @(posedge aclk);
    wr(8'h10, 8'h5a);
    rd(8'h00);
    chk("flag_lag", got[4], 1);
    rd(8'h00);
    chk("flag_full", got[4], 0);
    wait_rx(8'd2);
    chk("b2b_a", rx_char, 9'h096);
    wait_rx(8'd3);
    chk("b2b_b", rx_char, 9'h05a);
    wr(8'h14, 8'h20);
    wr(8'h18, 8'h01);
    bit_clks = 16'd128;
    wr(8'h10, 8'h81);
    start_len();
    chk("bit128", len, 128);
    wait_rx(8'd4);
    chk("slow", rx_char, 9'h081);
    wr(8'h18, 8'h00);
    bit_clks = 16'd16;
    wr(8'h14, 8'h65);
    nine = 1'b1;
    wr(8'h10, 8'h3c);
    wait_rx(8'd5);
    chk("nine", rx_char, 9'h13c);
    wr(8'h1c, 8'h01);
    wr(8'h10, 8'h22);
    repeat (400) @(posedge aclk);
    chk("sleep", rx_count, 5);
    wr(8'h1c, 8'h00);
    wait_rx(8'd6);
    chk("wake", rx_char, 9'h122);
    wr(8'h14, 8'h34);
    wr(8'h10, 8'h11);
    repeat (400) @(posedge aclk);
    chk("sync", rx_count, 6);
    chk("sync_idle", tx_line, 1);
    wrap_up();
  end
endmodule
